// file: logic/pcs_sequencer.sv
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module pcs_sequencer #(
    parameter int PC_W = pcs_pkg::PC_WIDTH
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Core view
    output logic [10:0] PC_OUT,
    output logic DUMMY_OUT,
    output logic FETCH_OUT
);
    // Only the eleven-bit counter is supported by the logic below
    if (PC_W != pcs_pkg::PC_WIDTH) begin
        $error("PC_W must be 11");
    end

    pcs_pkg::pcs_phase_t phase;
    logic t1_start;

    pcs_phase_gen u_phase (
        .CLK_IN(CLK_IN),
        .RST_IN(RST_IN),
        .phase_out(phase),
        .t1_start_out(t1_start)
    );

    logic [10:0] pc_q, pc_d;
    logic dummy_q, dummy_d;
    logic fetch_q, fetch_d;
    logic step_q, step_d;
    logic skip_q, skip_d;
    logic load_q, load_d;
    logic low_wr_q, low_wr_d;
    logic [7:0] low_val_q, low_val_d;
    logic [10:0] tgt_q, tgt_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic acc, wr, unmapped;

    // Splice a new low byte under the current page
    function automatic logic [10:0] page_splice(input logic [10:0] pc, input logic [7:0] lo);
        page_splice = {pc[10:8], lo};
    endfunction

    assign acc = PSEL_IN && PENABLE_IN;
    assign wr = acc && PWRITE_IN;
    assign unmapped = (PADDR_IN != pcs_pkg::ADDR_PC_LOW) && (PADDR_IN != pcs_pkg::ADDR_CTRL)
        && (PADDR_IN != pcs_pkg::ADDR_PC_FULL) && (PADDR_IN != pcs_pkg::ADDR_STATUS);

    // Pending requests latched from the bus, consumed at T1
    always_comb begin
        step_d = step_q;
        skip_d = skip_q;
        load_d = load_q;
        low_wr_d = low_wr_q;
        low_val_d = low_val_q;
        tgt_d = tgt_q;
        if (t1_start) begin
            step_d = 1'b0;
            skip_d = 1'b0;
            load_d = 1'b0;
            low_wr_d = 1'b0;
        end
        // New request wins; a request consumed at this T1 is not replayed
        if (wr && PADDR_IN == pcs_pkg::ADDR_CTRL) begin
            step_d = step_d | PWDATA_IN[pcs_pkg::CTRL_STEP_BIT];
            skip_d = skip_d | PWDATA_IN[pcs_pkg::CTRL_SKIP_BIT];
            load_d = load_d | PWDATA_IN[pcs_pkg::CTRL_LOAD_BIT];
            tgt_d = PWDATA_IN[pcs_pkg::CTRL_TGT_LSB +: 11];
        end
        if (wr && PADDR_IN == pcs_pkg::ADDR_PC_LOW) begin
            low_wr_d = 1'b1;
            low_val_d = PWDATA_IN[7:0];
        end
    end

    // Counter next value; priority load, low write, skip, step
    always_comb begin
        pc_d = pc_q;
        dummy_d = dummy_q;
        fetch_d = t1_start;
        if (t1_start) begin
            dummy_d = 1'b0;
            if (load_q) begin
                pc_d = tgt_q;
                dummy_d = 1'b1;
            end else if (low_wr_q) begin
                pc_d = page_splice(pc_q, low_val_q);
                dummy_d = 1'b1;
            end else if (skip_q) begin
                pc_d = pc_q + pcs_pkg::PC_STEP;
                dummy_d = 1'b1;
            end else if (step_q) begin
                pc_d = pc_q + pcs_pkg::PC_STEP;
            end
        end
    end

    // APB answer, zero wait states
    always_comb begin
        prdata_d = 32'h0000_0000;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (PSEL_IN && !PENABLE_IN) begin
            pready_d = 1'b1;
            pslverr_d = unmapped;
            if (!PWRITE_IN) begin
                unique case (PADDR_IN)
                    pcs_pkg::ADDR_PC_LOW: prdata_d = {24'h00_0000, pc_q[7:0]};
                    pcs_pkg::ADDR_CTRL: prdata_d = {13'h0000, tgt_q, 5'h00, load_q,
                        skip_q, step_q};
                    pcs_pkg::ADDR_PC_FULL: prdata_d = {21'h00_0000, pc_q};
                    pcs_pkg::ADDR_STATUS: prdata_d = {26'h000_0000, phase, 3'h0, dummy_q};
                    default: prdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    // All state registers
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pc_q <= pcs_pkg::PC_RESET;
            dummy_q <= 1'b0;
            fetch_q <= 1'b0;
            step_q <= 1'b0;
            skip_q <= 1'b0;
            load_q <= 1'b0;
            low_wr_q <= 1'b0;
            low_val_q <= 8'h00;
            tgt_q <= 11'h000;
            PRDATA_OUT <= 32'h0000_0000;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end else begin
            pc_q <= pc_d;
            dummy_q <= dummy_d;
            fetch_q <= fetch_d;
            step_q <= step_d;
            skip_q <= skip_d;
            load_q <= load_d;
            low_wr_q <= low_wr_d;
            low_val_q <= low_val_d;
            tgt_q <= tgt_d;
            PRDATA_OUT <= prdata_d;
            PREADY_OUT <= pready_d;
            PSLVERR_OUT <= pslverr_d;
        end
    end

    assign PC_OUT = pc_q;
    assign DUMMY_OUT = dummy_q;
    assign FETCH_OUT = fetch_q;

    sequence low_write_s;
        t1_start && !load_q && low_wr_q;
    endsequence

    // Dummy flag held for one whole instruction cycle
    sequence dummy_run_s;
        dummy_q[*4];
    endsequence

    property page_keep_p;
        @(posedge CLK_IN) disable iff (RST_IN)
        low_write_s |=> pc_q == {$past(pc_q[10:8]), $past(low_val_q)};
    endproperty

    step_one_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        t1_start && step_q && !load_q && !low_wr_q && !skip_q |=> pc_q == $past(pc_q) + 11'h001)
        else $error("pc did not step by one");
    low_read_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN == pcs_pkg::ADDR_PC_LOW
        |=> PRDATA_OUT == {24'h00_0000, $past(pc_q[7:0])})
        else $error("low byte read wrong");
    target_load_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        t1_start && load_q |=> pc_q == $past(tgt_q) && dummy_q)
        else $error("target not loaded");
    skip_dummy_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        t1_start && skip_q && !load_q && !low_wr_q
        |=> dummy_run_s ##1 dummy_q == $past(load_q || low_wr_q || skip_q))
        else $error("skip dummy cycle wrong");
    ready_pulse_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        PSEL_IN && !PENABLE_IN |=> PREADY_OUT ##1 !PREADY_OUT)
        else $error("bus answer not a single pulse");
    fetch_mark_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        t1_start |=> FETCH_OUT ##1 !FETCH_OUT)
        else $error("fetch mark not after T1");
    low_write_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        wr && PADDR_IN == pcs_pkg::ADDR_PC_LOW |=> low_wr_q)
        else $error("low write not captured");
    page_keep_a: assert property (page_keep_p)
        else $error("page bits changed on low write");
    low_dummy_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        low_write_s |=> dummy_q)
        else $error("no dummy after low write");
    t1_only_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        !t1_start |=> $stable(pc_q))
        else $error("pc changed outside T1");
    reset_zero_a: assert property (@(posedge CLK_IN)
        $fell(RST_IN) |-> pc_q == 11'h000)
        else $error("pc not zero after reset");
endmodule

// file: logic/pcs_pkg.sv
package pcs_pkg;
    // Counter geometry
    localparam int PC_WIDTH = 11;
    localparam int LOW_WIDTH = 8;
    localparam logic [10:0] PC_RESET = 11'h000;
    localparam logic [10:0] PC_STEP = 11'h001;
    // APB register map (byte addresses)
    localparam logic [7:0] ADDR_PC_LOW = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_PC_FULL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    // Control register fields
    localparam int CTRL_STEP_BIT = 0;
    localparam int CTRL_SKIP_BIT = 1;
    localparam int CTRL_LOAD_BIT = 2;
    localparam int CTRL_TGT_LSB = 8;
    // Status register fields
    localparam int STAT_DUMMY_BIT = 0;
    localparam int STAT_PHASE_LSB = 4;
    // Instruction-cycle phase machine
    typedef enum logic [1:0] {
        PCS_T1 = 2'b00,
        PCS_T2 = 2'b01,
        PCS_T3 = 2'b10,
        PCS_T4 = 2'b11
    } pcs_phase_t;
endpackage

// file: logic/pcs_phase_gen.sv
`timescale 1ns/1ps
module pcs_phase_gen (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // Phase outputs
    output pcs_pkg::pcs_phase_t phase_out,
    output logic t1_start_out
);
    pcs_pkg::pcs_phase_t phase_q, phase_d;

    // Four non-overlapping phases in rotation
    always_comb begin
        unique case (phase_q)
            pcs_pkg::PCS_T1: phase_d = pcs_pkg::PCS_T2;
            pcs_pkg::PCS_T2: phase_d = pcs_pkg::PCS_T3;
            pcs_pkg::PCS_T3: phase_d = pcs_pkg::PCS_T4;
            pcs_pkg::PCS_T4: phase_d = pcs_pkg::PCS_T1;
        endcase
    end

    // Phase register
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            phase_q <= pcs_pkg::PCS_T1;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase_out = phase_q;
    assign t1_start_out = (phase_q == pcs_pkg::PCS_T1);
endmodule

// file: bench/program_counter_sequencer_tb_top.sv
`timescale 1ns/1ps
module program_counter_sequencer_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [10:0] pc;
    logic dummy;
    logic fetch;
    logic [31:0] rd;
    logic err;
    int bad_count = 0;
    int checked = 0;
    int dummy_cnt = 0;
    int fetch_cnt = 0;
    int f0;

    // Clock generation
    initial begin
        forever #5 clk = ~clk;
    end

    // Device under test
    pcs_sequencer i_dut (
        .CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .PC_OUT(pc), .DUMMY_OUT(dummy), .FETCH_OUT(fetch)
    );

    // Count dummy and fetch cycles where outputs are settled
    always @(negedge clk) begin
        if (dummy === 1'b1) dummy_cnt++;
        if (fetch === 1'b1) fetch_cnt++;
    end

    // Compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] data, output logic slverr);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            $display("Bus wait expired");
            end_sim();
        end
        data = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // Write, let the instruction cycle pass, then check pc and dummy count
    task automatic op(input logic [7:0] a, input logic [31:0] wd, input logic [10:0] exp_pc,
            input int exp_dummy);
        int d0;
        d0 = dummy_cnt;
        apb(1'b1, a, wd, rd, err);
        repeat (14) @(posedge clk);
        apb(1'b0, pcs_pkg::ADDR_PC_FULL, 32'h00000000, rd, err);
        chk(rd, {21'h000000, exp_pc});
        chk({21'h000000, pc}, {21'h000000, exp_pc});
        if (exp_dummy >= 0) chk(32'(dummy_cnt - d0), 32'(exp_dummy));
        $display("Test write %h data %h done", a, wd);
    endtask

    // Verdict and end of run
    task automatic end_sim;
        $display("Comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #100us;
        bad_count++;
        $display("Watchdog expired");
        end_sim();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, pcs_pkg::ADDR_PC_FULL, 32'h00000000, rd, err);
        chk(rd, 32'h00000000);
        chk({21'h000000, pc}, 32'h00000000);
        $display("Test reset value done");
        f0 = fetch_cnt;
        repeat (16) @(posedge clk);
        chk(32'(fetch_cnt - f0), 32'h00000004);
        $display("Test fetch rate done");
        op(pcs_pkg::ADDR_CTRL, 32'h00000001, 11'h001, 0);
        op(pcs_pkg::ADDR_CTRL, 32'h0002ff04, 11'h2ff, -1);
        apb(1'b0, pcs_pkg::ADDR_CTRL, 32'h00000000, rd, err);
        chk(rd, 32'h0002ff00);
        chk({31'h00000000, err}, 32'h00000000);
        $display("Test request clear done");
        op(pcs_pkg::ADDR_CTRL, 32'h00000001, 11'h300, 0);
        op(pcs_pkg::ADDR_PC_LOW, 32'h000007ab, 11'h3ab, 4);
        apb(1'b0, pcs_pkg::ADDR_PC_LOW, 32'h00000000, rd, err);
        chk(rd, 32'h000000ab);
        op(pcs_pkg::ADDR_CTRL, 32'h00000002, 11'h3ac, 4);
        apb(1'b0, 8'h10, 32'h00000000, rd, err);
        chk({31'h00000000, err}, 32'h00000001);
        chk(rd, 32'h00000000);
        apb(1'b0, pcs_pkg::ADDR_STATUS, 32'h00000000, rd, err);
        chk(rd & 32'hffffffcf, 32'h00000000);
        $display("Test unmapped read done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk({21'h000000, pc}, 32'h00000000);
        rst <= 1'b0;
        apb(1'b0, pcs_pkg::ADDR_PC_FULL, 32'h00000000, rd, err);
        chk(rd, 32'h00000000);
        op(pcs_pkg::ADDR_CTRL, 32'h00000001, 11'h001, 0);
        $display("Test mid-run reset done");
        end_sim();
    end
endmodule
